// >>> rtl/lqc_consts.svh
`ifndef LQC_CONSTS_SVH
`define LQC_CONSTS_SVH

// register byte offsets
`define LQC_OFS_CTRL       12'h000
`define LQC_OFS_STATUS     12'h004
`define LQC_OFS_TXLEVEL    12'h008
`define LQC_OFS_TIMER      12'h00c

// control fields
`define LQC_CTRL_START     0
`define LQC_CTRL_LCAP      1
`define LQC_CTRL_LREQ      2
`define LQC_CTRL_RST       32'h0000_0000

// status fields
`define LQC_ST_BUSY        0
`define LQC_ST_DONE        1
`define LQC_ST_PASS        2
`define LQC_ST_FEC         3
`define LQC_ST_CODE66      4
`define LQC_ST_RCAP        5
`define LQC_ST_RREQ        6

// transmit path
`define LQC_WORD_W         32
`define LQC_FIFO_DEPTH     16
`define LQC_NOS_WORD       32'h5a5a_0001

// timing
`define LQC_CLK_PERIOD_NS  5
`define LQC_TEST_TIME_NS   1000000

`endif

// >>> rtl/lqc_pkg.sv
package lqc_pkg;
  typedef enum logic {
    LQC_IDLE,
    LQC_TEST
  } lqc_state_t;

  typedef logic [31:0] lqc_word_t;
endpackage : lqc_pkg

// >>> rtl/lqc_fifo.sv
`timescale 1ns/100ps
module lqc_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  // fill side
  input  wire logic                     in_valid,
  output logic                          in_ready,
  input  wire logic [WIDTH-1:0]         in_data,
  // drain side
  output logic                          out_valid,
  input  wire logic                     out_ready,
  output logic [WIDTH-1:0]              out_data,
  // fill level
  output logic [$clog2(DEPTH):0]        level
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q, wr_d;
  logic [AW-1:0]    rd_q, rd_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem[rd_q];
  assign level     = cnt_q;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    wr_d  = push ? wr_q + 1'b1 : wr_q;
    rd_d  = pop ? rd_q + 1'b1 : rd_q;
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // storage has no reset: contents are only read once counted in
  always_ff @(posedge pclk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end
endmodule : lqc_fifo

// >>> rtl/lqc_link_check.sv
`timescale 1ns/100ps
`include "lqc_consts.svh"

// Notes on behaviour
// - send not-operational sequence while checker runs
// - entering test switches transmitter to 64b/66b
// - fec off if either side incapable
// - fec off if nobody requests it
// - fec on: both capable, one requests
// - start test interval timer on entry
// - fec choice frozen until timer expires
// - sync at expiry reports success
// - no sync at expiry reports failure
// - on success code and fec persist
module lqc_link_check #(
  parameter int unsigned TEST_CYCLES =
    (`LQC_TEST_TIME_NS + `LQC_CLK_PERIOD_NS - 1) / `LQC_CLK_PERIOD_NS
) (
  // clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // apb slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic                      pready,
  output lqc_pkg::lqc_word_t        prdata,
  output logic                      pslverr,
  // sequencer handshake
  input  wire logic                 lqc_start,
  output logic                      lqc_busy,
  output logic                      lqc_done,
  output logic                      lqc_pass,
  // remote flags and receiver status
  input  wire logic                 remote_fec_capable,
  input  wire logic                 remote_fec_request,
  input  wire logic                 word_sync,
  // transmitter control
  output logic                      tx_code_66b,
  output logic                      tx_fec_enable,
  // transmit word stream
  output logic                      tx_valid,
  input  wire logic                 tx_ready,
  output lqc_pkg::lqc_word_t        tx_data
);
  import lqc_pkg::*;

  localparam int LW = $clog2(`LQC_FIFO_DEPTH) + 1;
  localparam lqc_word_t CTRL_RST = `LQC_CTRL_RST;

  // apb state
  logic             pready_q, pready_d;
  logic             pslverr_q, pslverr_d;
  lqc_word_t        prdata_q, prdata_d;
  logic             lcap_q, lcap_d;
  logic             lreq_q, lreq_d;
  logic             sw_start;
  logic             acc_ok;
  logic             wr_take;

  // checker state
  lqc_state_t       st_q, st_d;
  logic [31:0]      tmr_q, tmr_d;
  logic             code_q, code_d;
  logic             fec_q, fec_d;
  logic             done_q, done_d;
  logic             sdone_q, sdone_d;
  logic             pass_q, pass_d;
  logic             busy_q, busy_d;
  logic             start_go;
  logic             expire;
  logic             fec_pick;

  // transmit path
  logic             fq_in_ready;
  logic             fq_out_valid;
  lqc_word_t        fq_out_data;
  logic [LW-1:0]    fq_level;
  logic             fq_pop;
  logic             txv_q, txv_d;
  lqc_word_t        txd_q, txd_d;

  // apb decode
  always_comb begin
    acc_ok = 1'b0;
    unique case (paddr)
      `LQC_OFS_CTRL, `LQC_OFS_STATUS,
      `LQC_OFS_TXLEVEL, `LQC_OFS_TIMER: acc_ok = 1'b1;
      default: acc_ok = 1'b0;
    endcase
  end

  // one wait state: the access ends at the edge after pready rises
  assign wr_take  = psel && penable && pready_q && pwrite &&
                    (paddr == `LQC_OFS_CTRL);
  assign sw_start = wr_take && pwdata[`LQC_CTRL_START];

  always_comb begin
    pready_d  = psel && penable && !pready_q;
    pslverr_d = psel && penable && !pready_q && !acc_ok;
    prdata_d  = '0;
    if (psel && penable && !pready_q && !pwrite) begin
      unique case (paddr)
        `LQC_OFS_CTRL: begin
          prdata_d[`LQC_CTRL_LCAP] = lcap_q;
          prdata_d[`LQC_CTRL_LREQ] = lreq_q;
        end
        `LQC_OFS_STATUS: begin
          prdata_d[`LQC_ST_BUSY]   = busy_q;
          prdata_d[`LQC_ST_DONE]   = sdone_q;
          prdata_d[`LQC_ST_PASS]   = pass_q;
          prdata_d[`LQC_ST_FEC]    = fec_q;
          prdata_d[`LQC_ST_CODE66] = code_q;
          prdata_d[`LQC_ST_RCAP]   = remote_fec_capable;
          prdata_d[`LQC_ST_RREQ]   = remote_fec_request;
        end
        `LQC_OFS_TXLEVEL: prdata_d[LW-1:0] = fq_level;
        `LQC_OFS_TIMER:   prdata_d = tmr_q;
        default:          prdata_d = '0;
      endcase
    end
    lcap_d = wr_take ? pwdata[`LQC_CTRL_LCAP] : lcap_q;
    lreq_d = wr_take ? pwdata[`LQC_CTRL_LREQ] : lreq_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
      lcap_q    <= CTRL_RST[`LQC_CTRL_LCAP];
      lreq_q    <= CTRL_RST[`LQC_CTRL_LREQ];
    end else begin
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q  <= prdata_d;
      lcap_q    <= lcap_d;
      lreq_q    <= lreq_d;
    end
  end

  // checker
  // a start while the test runs is ignored so the timer is never cut short
  assign start_go = (st_q == LQC_IDLE) && (lqc_start || sw_start);
  assign expire   = (st_q == LQC_TEST) && (tmr_q == 32'(TEST_CYCLES - 1));
  assign fec_pick = lcap_q && remote_fec_capable &&
                    (lreq_q || remote_fec_request);

  always_comb begin
    st_d    = st_q;
    tmr_d   = tmr_q;
    code_d  = code_q;
    fec_d   = fec_q;
    done_d  = 1'b0;
    sdone_d = sdone_q;
    pass_d  = pass_q;
    unique case (st_q)
      LQC_IDLE: begin
        if (start_go) begin
          st_d    = LQC_TEST;
          tmr_d   = '0;
          code_d  = 1'b1;
          fec_d   = fec_pick;
          sdone_d = 1'b0;
          pass_d  = 1'b0;
        end
      end
      LQC_TEST: begin
        // fec_d changes here only on a failed expiry: the flags are not looked at again
        tmr_d = tmr_q + 32'h0000_0001;
        if (expire) begin
          st_d    = LQC_IDLE;
          done_d  = 1'b1;
          sdone_d = 1'b1;
          pass_d  = word_sync;
          if (!word_sync) begin
            // a failed check hands the line coding back to the sequencer
            code_d = 1'b0;
            fec_d  = 1'b0;
          end
        end
      end
    endcase
    busy_d = (st_d == LQC_TEST);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q    <= LQC_IDLE;
      tmr_q   <= '0;
      code_q  <= 1'b0;
      fec_q   <= 1'b0;
      done_q  <= 1'b0;
      sdone_q <= 1'b0;
      pass_q  <= 1'b0;
      busy_q  <= 1'b0;
    end else begin
      st_q    <= st_d;
      tmr_q   <= tmr_d;
      code_q  <= code_d;
      fec_q   <= fec_d;
      done_q  <= done_d;
      sdone_q <= sdone_d;
      pass_q  <= pass_d;
      busy_q  <= busy_d;
    end
  end

  // transmit words queue up; a stalled link back-pressures the filler
  lqc_fifo #(
    .WIDTH (`LQC_WORD_W),
    .DEPTH (`LQC_FIFO_DEPTH)
  ) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (busy_q),
    .in_ready  (fq_in_ready),
    .in_data   (`LQC_NOS_WORD),
    .out_valid (fq_out_valid),
    .out_ready (fq_pop),
    .out_data  (fq_out_data),
    .level     (fq_level)
  );

  // output stage keeps tx outputs straight from flops
  assign fq_pop = fq_out_valid && (!txv_q || tx_ready);

  always_comb begin
    txv_d = txv_q;
    txd_d = txd_q;
    if (fq_pop) begin
      txv_d = 1'b1;
      txd_d = fq_out_data;
    end else if (tx_ready) begin
      txv_d = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txv_q <= 1'b0;
      txd_q <= '0;
    end else begin
      txv_q <= txv_d;
      txd_q <= txd_d;
    end
  end

  assign pready        = pready_q;
  assign prdata        = prdata_q;
  assign pslverr       = pslverr_q;
  assign lqc_busy      = busy_q;
  assign lqc_done      = done_q;
  assign lqc_pass      = pass_q;
  assign tx_code_66b   = code_q;
  assign tx_fec_enable = fec_q;
  assign tx_valid      = txv_q;
  assign tx_data       = txd_q;

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_nos_words: assert property (
    txv_q |-> txd_q == `LQC_NOS_WORD)
    else $error("transmitted word is not the not-operational word");

  a_entry_code: assert property (
    start_go |=> code_q && busy_q && st_q == LQC_TEST)
    else $error("entry did not select 64b/66b code");

  a_fec_cap_off: assert property (
    start_go && !(lcap_q && remote_fec_capable) |=> !fec_q)
    else $error("fec enabled without both capabilities");

  a_fec_req_off: assert property (
    start_go && !(lreq_q || remote_fec_request) |=> !fec_q)
    else $error("fec enabled without any request");

  a_fec_on: assert property (
    start_go && lcap_q && remote_fec_capable &&
    (lreq_q || remote_fec_request) |=> fec_q)
    else $error("fec not enabled though capable and requested");

  a_timer_expiry: assert property (
    done_q |-> $past(tmr_q) == 32'(TEST_CYCLES - 1) && !busy_q)
    else $error("test ended before the timer expired");

  a_fec_frozen: assert property (
    st_q == LQC_TEST ##1 st_q == LQC_TEST |-> $stable(fec_q) && code_q)
    else $error("fec choice changed during the test");

  a_pass_result: assert property (
    expire && word_sync |=> done_q && pass_q ##1 !done_q)
    else $error("synchronised test not reported as passed");

  a_fail_result: assert property (
    expire && !word_sync |=> done_q && !pass_q && !code_q)
    else $error("unsynchronised test not reported as failed");

  a_keep_code: assert property (
    pass_q && !busy_q && !start_go |=> $stable(code_q) && $stable(fec_q))
    else $error("line coding changed after a successful check");

  a_apb_wait: assert property (
    psel && penable && !pready_q |=> pready_q ##1 !pready_q)
    else $error("apb answer not exactly one cycle after access");

  a_done_pulse: assert property (
    done_q |=> !done_q)
    else $error("done held longer than one cycle");

  a_busy_hold: assert property (
    busy_q && !expire |=> busy_q && st_q == LQC_TEST)
    else $error("test left before the timer expired");

  a_timer_start: assert property (
    start_go |=> tmr_q == 32'h0000_0000)
    else $error("test timer not cleared on entry");

  a_timer_step: assert property (
    st_q == LQC_TEST && !expire |=> tmr_q == $past(tmr_q) + 32'h0000_0001)
    else $error("test timer did not advance by one");

  a_fail_fec_off: assert property (
    expire && !word_sync |=> !fec_q && !busy_q)
    else $error("fec still on after a failed check");

  a_pass_keep: assert property (
    expire && word_sync |=> code_q && fec_q == $past(fec_q))
    else $error("coding or fec changed on a successful check");

  a_result_hold: assert property (
    !busy_q && !start_go |=> $stable(pass_q))
    else $error("result changed while idle");

  a_tx_hold: assert property (
    txv_q && !tx_ready |=> txv_q && $stable(txd_q))
    else $error("stalled transmit word dropped or changed");

  c_pass:      cover property (expire && word_sync);
  c_fail:      cover property (expire && !word_sync);
  c_fec_entry: cover property (start_go && fec_pick);
  c_tx_stall:  cover property (busy_q && !fq_in_ready);
  c_reg_start: cover property (start_go && sw_start);
endmodule : lqc_link_check

// >>> testbench/lqc_remote_port.sv
`timescale 1ns/100ps
`include "lqc_consts.svh"
module lqc_remote_port
  import lqc_pkg::*;
(
  // clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // settings from the bench
  input  wire logic                cap_set,
  input  wire logic                req_set,
  input  wire logic                sync_set,
  input  wire logic                stall,
  // link side
  input  wire logic                tx_valid,
  input  wire lqc_pkg::lqc_word_t  tx_data,
  output logic                     tx_ready,
  output logic                     remote_fec_capable,
  output logic                     remote_fec_request,
  output logic                     word_sync,
  // word tally
  output int                       words,
  output int                       bad_words
);
  // flags lag one edge, as a real receiver's decoded fields would
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_ready <= 1'b0;
      remote_fec_capable <= 1'b0;
      remote_fec_request <= 1'b0;
      word_sync <= 1'b0;
      words <= 0;
      bad_words <= 0;
    end else begin
      tx_ready <= !stall;
      remote_fec_capable <= cap_set;
      remote_fec_request <= req_set;
      word_sync <= sync_set;
      if (tx_valid && tx_ready) begin
        words <= words + 1;
        if (tx_data !== `LQC_NOS_WORD) bad_words <= bad_words + 1;
      end
    end
  end
endmodule : lqc_remote_port

// >>> testbench/lqc_link_check_tb.sv
`timescale 1ns/100ps
`include "lqc_consts.svh"
module lqc_link_check_tb;
  import lqc_pkg::*;
  localparam int TC = 20;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        lqc_start = 1'b0;
  logic        cap_set = 1'b0;
  logic        req_set = 1'b0;
  logic        sync_set = 1'b0;
  logic        stall = 1'b0;
  logic        pready, pslverr, lqc_busy, lqc_done, lqc_pass;
  logic        word_sync, tx_code_66b, tx_fec_enable, tx_valid, tx_ready;
  logic        remote_fec_capable, remote_fec_request;
  lqc_word_t   prdata, tx_data;
  int          words, bad_words;
  int          fails = 0;
  int          samples_checked = 0;

  always #2.5 pclk = ~pclk;

  lqc_link_check #(.TEST_CYCLES(TC)) lqc_link_check_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .lqc_start(lqc_start),
    .lqc_busy(lqc_busy), .lqc_done(lqc_done), .lqc_pass(lqc_pass),
    .remote_fec_capable(remote_fec_capable),
    .remote_fec_request(remote_fec_request), .word_sync(word_sync),
    .tx_code_66b(tx_code_66b), .tx_fec_enable(tx_fec_enable),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data));

  lqc_remote_port lqc_remote_port_inst (
    .pclk(pclk), .presetn(presetn), .cap_set(cap_set),
    .req_set(req_set), .sync_set(sync_set), .stall(stall),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .remote_fec_capable(remote_fec_capable),
    .remote_fec_request(remote_fec_request), .word_sync(word_sync),
    .words(words), .bad_words(bad_words));

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // a wait that ran out ends the run at once
  task automatic tout();
    chk(32'h0, 32'h1);
    close_out();
  endtask : tout

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic er);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) tout();
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic reg_check();
    logic [31:0] rd;
    logic        er;
    apb(1'b0, `LQC_OFS_CTRL, 32'h0, rd, er);
    chk(rd, `LQC_CTRL_RST);
    apb(1'b1, `LQC_OFS_STATUS, 32'hffff_ffff, rd, er);
    chk(er, 1'b0);
    apb(1'b0, `LQC_OFS_STATUS, 32'h0, rd, er);
    chk(rd, 32'h0);
    apb(1'b0, `LQC_OFS_TIMER, 32'h0, rd, er);
    chk(rd, 32'h0);
    apb(1'b1, `LQC_OFS_CTRL, 32'h6, rd, er);
    apb(1'b0, `LQC_OFS_CTRL, 32'h0, rd, er);
    chk(rd, 32'h6);
    apb(1'b1, 12'h010, 32'h6, rd, er);
    chk(er, 1'b1);
    apb(1'b0, 12'h010, 32'h0, rd, er);
    chk(rd, 32'h0);
    chk(er, 1'b1);
  endtask : reg_check

  // remote flags flip mid-test and a stray start arrives while busy
  task automatic run_check(input logic lc, lr, rc, rr, sy, by_reg);
    logic [31:0] rd;
    logic        er;
    logic        fec;
    int          n;
    fec = lc & rc & (lr | rr);
    @(posedge pclk);
    cap_set <= rc;
    req_set <= rr;
    sync_set <= sy;
    apb(1'b1, `LQC_OFS_CTRL, {29'h0, lr, lc, 1'b0}, rd, er);
    if (by_reg) begin
      apb(1'b1, `LQC_OFS_CTRL, {29'h0, lr, lc, 1'b1}, rd, er);
    end else begin
      @(posedge pclk);
      lqc_start <= 1'b1;
      @(posedge pclk);
      lqc_start <= 1'b0;
    end
    @(negedge pclk);
    chk(lqc_busy, 1'b1);
    chk(tx_code_66b, 1'b1);
    chk(tx_fec_enable, fec);
    n = 0;
    while (lqc_done !== 1'b1 && n < TC + 8) begin
      @(posedge pclk);
      lqc_start <= (n == 3);
      cap_set <= ~rc;
      req_set <= ~rr;
      @(negedge pclk);
      n++;
      chk(tx_fec_enable, (lqc_done === 1'b1) ? (fec & sy) : fec);
    end
    if (lqc_done !== 1'b1) tout();
    chk(n, TC);
    chk(lqc_pass, sy);
    chk(tx_code_66b, sy);
    chk(bad_words, 0);
    chk(32'(words != 0), 32'h1);
    apb(1'b0, `LQC_OFS_STATUS, 32'h0, rd, er);
    // remote flags were flipped during the test and still read flipped
    chk(rd, {25'h0, ~rr, ~rc, sy, fec & sy, sy, 1'b1, 1'b0});
  endtask : run_check

  // far side stalls the whole test, then drains the buffer
  task automatic fifo_check();
    logic [31:0] rd;
    logic        er;
    int          n;
    @(posedge pclk);
    stall <= 1'b1;
    lqc_start <= 1'b1;
    @(posedge pclk);
    lqc_start <= 1'b0;
    n = 0;
    while (lqc_done !== 1'b1 && n < TC + 8) begin
      @(negedge pclk);
      n++;
    end
    if (lqc_done !== 1'b1) tout();
    apb(1'b0, `LQC_OFS_TXLEVEL, 32'h0, rd, er);
    chk(rd, `LQC_FIFO_DEPTH);
    chk(tx_valid, 1'b1);
    @(posedge pclk);
    stall <= 1'b0;
    n = 0;
    while (tx_valid !== 1'b0 && n < 60) begin
      @(negedge pclk);
      n++;
    end
    if (tx_valid !== 1'b0) tout();
    apb(1'b0, `LQC_OFS_TXLEVEL, 32'h0, rd, er);
    chk(rd, 32'h0);
    chk(bad_words, 0);
  endtask : fifo_check

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    reg_check();
    for (int i = 0; i < 16; i++) begin
      run_check(i[0], i[1], i[2], i[3], i[0] ^ i[2], i[1]);
    end
    fifo_check();
    close_out();
  end
endmodule : lqc_link_check_tb
